// ---- inc/dasp_pkg.sv ----
// Constants, register map and shared helpers of the digital audio serial port.
`default_nettype none
package dasp_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int SAMPLE_W = 16;
	localparam int RX_W = 24;
	localparam int CNT_W = 6;

	// Register offsets.
	localparam logic [2:0] REG_CONFIG = 3'h0;
	localparam logic [2:0] REG_CTRL = 3'h1;
	localparam logic [2:0] REG_TX_LEFT = 3'h2;
	localparam logic [2:0] REG_TX_RIGHT = 3'h3;
	localparam logic [2:0] REG_RX_LEFT = 3'h4;
	localparam logic [2:0] REG_RX_RIGHT = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;

	// Fields of audio_format_config.
	localparam int CFG_JUSTIFY_BIT = 0;
	localparam int CFG_MSB_DELAY_BIT = 1;
	localparam int CFG_POLARITY_BIT = 2;
	localparam int CFG_ATTEN_EN_BIT = 3;
	localparam int CFG_ATTEN_LSB = 4;
	localparam int CFG_RES_LSB = 8;
	localparam int CFG_CROP_BIT = 10;
	localparam logic [15:0] CFG_MASK = 16'h07ff;
	localparam logic [15:0] CFG_RESET = 16'h0406;

	// Fields of the control and status registers.
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MASTER_BIT = 1;
	localparam int CTRL_LSB_FIRST_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int STAT_RX_READY_BIT = 0;
	localparam int STAT_ACTIVE_BIT = 1;

	// Input resolution codes.
	localparam logic [1:0] RES_16 = 2'h0;
	localparam logic [1:0] RES_20 = 2'h1;
	localparam logic [1:0] RES_24 = 2'h2;

	// Link timing in nanoseconds and clock cycles.
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCK_HIGH_MIN_NS = 80;
	localparam int SCK_HALF_MIN_CYC = (SCK_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCK_HALF_DEFAULT = 4;
	localparam int SLOT_BITS_DEFAULT = 32;

	// Number of data bits for a resolution code; the reserved code acts as 16 bits.
	function automatic logic [4:0] res_bits(input logic [1:0] code);
		unique case (code)
			RES_20: res_bits = 5'd20;
			RES_24: res_bits = 5'd24;
			default: res_bits = 5'd16;
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- verilog/dasp_sample_conv.sv ----
// Sample width conversion: received word to 16 bits and output attenuation.
`default_nettype none
module dasp_sample_conv (
	// Received word, right aligned.
	input  wire logic [dasp_pkg::RX_W-1:0]     rx_word,
	input  wire logic [1:0]                    input_resolution,
	input  wire logic                          input_crop_enable,
	output logic [dasp_pkg::SAMPLE_W-1:0]      rx_sample,
	// Sample to send.
	input  wire logic [dasp_pkg::SAMPLE_W-1:0] tx_sample,
	input  wire logic                          attenuation_enable,
	input  wire logic [3:0]                    attenuation_steps,
	output logic [dasp_pkg::SAMPLE_W-1:0]      tx_out
);
	import dasp_pkg::*;

	logic [RX_W-1:0]     aligned;
	logic [16:0]         top17;
	logic signed [23:0]  wide;
	logic signed [23:0]  shifted;
	logic signed [23:0]  rounded;

	// Received data: left align, then crop to 16 bits or round 17 bits to 16.
	always_comb begin
		aligned = rx_word << (5'd24 - res_bits(input_resolution));
		top17 = aligned[23:7];
		if (input_crop_enable) begin
			rx_sample = aligned[23:8];
		end else if (top17 == 17'h0ffff) begin
			rx_sample = 16'h7fff;
		end else begin
			rx_sample = 16'((top17 + 17'h00001) >> 1);
		end
	end

	// Output: 6 dB per step over 24 bits, rounded and saturated back to 16.
	always_comb begin
		wide = {tx_sample, 8'h00};
		shifted = wide >>> attenuation_steps;
		rounded = shifted + 24'sh000080;
		if (attenuation_enable && !input_crop_enable) begin
			if (!shifted[23] && rounded[23]) begin
				tx_out = 16'h7fff;
			end else begin
				tx_out = rounded[23:8];
			end
		end else begin
			tx_out = tx_sample;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/dasp_port.sv ----
// Digital audio serial port: link framing, pin sharing and register file.
// How it works
// - The link carries I2S, left-justified or right-justified framing as configured.
// - The port uses the four voice pins and drives none of them while it is disabled.
// - Configuration bit 0 selects left-justified when clear and right-justified when set.
// - In left-justified framing bit 1 puts the MSB in the first or second bit period.
// - Bit 2 clear makes WS-high data the left channel, set makes it the right channel.
// - Bit 3 clear sends samples unchanged; set with bit 10 clear applies attenuation over 24 bits, saturating.
// - Bits 7 to 4 give the attenuation, 6 dB for each step.
// - Bits 9 to 8 give the input resolution of 16, 20 or 24 bits.
// - Bit 10 clear rounds 17 received bits to 16, set keeps the 16 top bits.
// - Samples are 16 bits and at most 16 data bits per channel go out.
// - The word 0x0406 gives standard I2S with 16-bit data and is the reset value.
// - As master, the port drives bit clock and WS and moves WS and data on its falling edge.
//
// Chosen here: the address-and-strobe port and the register offsets.
`default_nettype none
module dasp_port #(
	parameter int SCK_HALF = dasp_pkg::SCK_HALF_DEFAULT,
	parameter int SLOT_BITS = dasp_pkg::SLOT_BITS_DEFAULT
) (
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        reset,
	// Register port.
	input  wire logic [dasp_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [dasp_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_write,
	input  wire logic                        reg_read,
	output logic [dasp_pkg::DATA_W-1:0]      reg_rdata,
	// Bit clock pin.
	input  wire logic                        sck_in,
	output logic                             sck_out,
	output logic                             sck_oe,
	// Word select pin.
	input  wire logic                        ws_in,
	output logic                             ws_out,
	output logic                             ws_oe,
	// Serial data pins.
	input  wire logic                        sd_in,
	output logic                             sd_out,
	output logic                             sd_oe,
	// Pin sharing with the voice interface.
	output logic                             pcm_owns_pins
);
	import dasp_pkg::*;

	logic [15:0]         config_reg;
	logic [2:0]          ctrl_reg;
	logic [15:0]         tx_left_reg, tx_right_reg, rx_left_reg, rx_right_reg;
	logic                rx_ready_reg;
	logic [15:0]         rdata_reg;
	logic [1:0]          sck_sync_reg, ws_sync_reg, sd_sync_reg;
	logic                sck_prev_reg;
	logic [7:0]          div_cnt_reg;
	logic                sck_out_reg, ws_out_reg, sd_out_reg;
	logic                sck_oe_reg, ws_oe_reg, sd_oe_reg, pcm_reg;
	logic [CNT_W-1:0]    mst_bit_reg;
	logic [1:0]          rise_pipe_reg;
	logic [CNT_W-1:0]    rx_cnt_reg, tx_cnt_reg, slot_len_reg;
	logic                rx_ws_reg, tx_ws_reg, rx_primed_reg;
	logic [RX_W-1:0]     rx_shift_reg;
	logic [15:0]         tx_word_reg;

	logic                en, master, lsb_first, right_just, msb_delay, polarity, crop;
	logic [1:0]          res;
	logic                div_wrap, m_rise, m_fall, s_rise, s_fall, rx_rise, tx_fall;
	logic                ws_rx, ws_tx, rx_bound, tx_bound, deliver, deliver_left;
	logic [RX_W-1:0]     rx_align;
	logic [15:0]         rx_conv, tx_pick, tx_conv;
	logic [CNT_W-1:0]    slot_len;

	assign en = ctrl_reg[CTRL_ENABLE_BIT];
	assign master = ctrl_reg[CTRL_MASTER_BIT];
	assign lsb_first = ctrl_reg[CTRL_LSB_FIRST_BIT];
	assign right_just = config_reg[CFG_JUSTIFY_BIT];
	assign msb_delay = config_reg[CFG_MSB_DELAY_BIT];
	assign polarity = config_reg[CFG_POLARITY_BIT];
	assign crop = config_reg[CFG_CROP_BIT];
	assign res = config_reg[CFG_RES_LSB +: 2];

	// Data bit that a period carries, or -1 when the period carries no data.
	function automatic int data_index(input logic [CNT_W-1:0] p, input logic [4:0] width,
		input logic [CNT_W-1:0] len);
		int k;
		k = right_just ? int'(p) - (int'(len) - int'(width)) : int'(p) - int'(msb_delay);
		data_index = (k >= 0 && k < int'(width)) ? k : -1;
	endfunction

	// Output bit of a 16-bit word for a bit period; spare periods carry zero.
	function automatic logic tx_bit(input logic [CNT_W-1:0] p, input logic [15:0] w);
		int k;
		k = data_index(p, 5'd16, slot_len);
		if (k < 0) begin
			tx_bit = 1'b0;
		end else begin
			tx_bit = lsb_first ? w[k] : w[15 - k];
		end
	endfunction

	// Pin inputs pass two flip-flops before the link logic looks at them.
	always_ff @(posedge clk) begin
		if (reset) begin
			sck_sync_reg <= 2'h0;
			ws_sync_reg <= 2'h0;
			sd_sync_reg <= 2'h0;
			sck_prev_reg <= 1'b0;
		end else begin
			sck_sync_reg <= {sck_sync_reg[0], sck_in};
			ws_sync_reg <= {ws_sync_reg[0], ws_in};
			sd_sync_reg <= {sd_sync_reg[0], sd_in};
			sck_prev_reg <= sck_sync_reg[1];
		end
	end

	// Edge events of the bit clock, generated or found on the pin.
	assign div_wrap = (div_cnt_reg == 8'(SCK_HALF - 1));
	assign m_rise = en && master && div_wrap && !sck_out_reg;
	assign m_fall = en && master && div_wrap && sck_out_reg;
	assign s_rise = en && !master && sck_sync_reg[1] && !sck_prev_reg;
	assign s_fall = en && !master && !sck_sync_reg[1] && sck_prev_reg;
	assign rx_rise = master ? rise_pipe_reg[1] : s_rise;
	assign tx_fall = master ? m_fall : s_fall;
	assign slot_len = master ? CNT_W'(SLOT_BITS) : slot_len_reg;
	assign ws_rx = master ? ws_out_reg : ws_sync_reg[1];
	assign ws_tx = master ? (ws_out_reg ^ (mst_bit_reg == CNT_W'(SLOT_BITS - 1)))
		: ws_sync_reg[1];
	assign rx_bound = rx_rise && (ws_rx != rx_ws_reg);
	assign tx_bound = tx_fall && (ws_tx != tx_ws_reg);
	assign deliver = rx_bound && rx_primed_reg;
	assign deliver_left = rx_ws_reg ^ polarity;
	assign tx_pick = (ws_tx ^ polarity) ? tx_left_reg : tx_right_reg;
	assign rx_align = lsb_first ? rx_shift_reg >> (5'd24 - res_bits(res)) : rx_shift_reg;

	dasp_sample_conv u_conv (
		.rx_word            (rx_align),
		.input_resolution   (res),
		.input_crop_enable  (crop),
		.rx_sample          (rx_conv),
		.tx_sample          (tx_pick),
		.attenuation_enable (config_reg[CFG_ATTEN_EN_BIT]),
		.attenuation_steps  (config_reg[CFG_ATTEN_LSB +: 4]),
		.tx_out             (tx_conv)
	);

	// Master bit clock and word select; WS moves only on a falling edge.
	always_ff @(posedge clk) begin
		if (reset || !en || !master) begin
			div_cnt_reg <= 8'h00;
			sck_out_reg <= 1'b0;
			ws_out_reg <= 1'b0;
			mst_bit_reg <= '0;
			rise_pipe_reg <= 2'h0;
		end else begin
			div_cnt_reg <= div_wrap ? 8'h00 : div_cnt_reg + 8'h01;
			rise_pipe_reg <= {rise_pipe_reg[0], m_rise};
			if (div_wrap) begin
				sck_out_reg <= !sck_out_reg;
			end
			if (m_fall) begin
				ws_out_reg <= ws_tx;
				mst_bit_reg <= (mst_bit_reg == CNT_W'(SLOT_BITS - 1)) ? '0 : mst_bit_reg + 1'b1;
			end
		end
	end

	// Pin ownership; the voice interface keeps the pins while the port is off.
	always_ff @(posedge clk) begin
		if (reset) begin
			sck_oe_reg <= 1'b0;
			ws_oe_reg <= 1'b0;
			sd_oe_reg <= 1'b0;
			pcm_reg <= 1'b1;
		end else begin
			sck_oe_reg <= en && master;
			ws_oe_reg <= en && master;
			sd_oe_reg <= en;
			pcm_reg <= !en;
		end
	end

	// Transmit: a new word at each WS change, one bit per falling edge.
	always_ff @(posedge clk) begin
		if (reset || !en) begin
			tx_cnt_reg <= '0;
			tx_ws_reg <= 1'b0;
			tx_word_reg <= 16'h0000;
			sd_out_reg <= 1'b0;
		end else if (tx_bound) begin
			tx_cnt_reg <= '0;
			tx_ws_reg <= ws_tx;
			tx_word_reg <= tx_conv;
			sd_out_reg <= tx_bit('0, tx_conv);
		end else if (tx_fall) begin
			if (tx_cnt_reg != '1) begin
				tx_cnt_reg <= tx_cnt_reg + 1'b1;
			end
			sd_out_reg <= tx_bit(tx_cnt_reg + 1'b1, tx_word_reg);
		end
	end

	// Receive: shift the data periods of a slot, hand the word on at the next WS change.
	always_ff @(posedge clk) begin
		if (reset || !en) begin
			rx_cnt_reg <= '0;
			rx_ws_reg <= 1'b0;
			rx_primed_reg <= 1'b0;
			rx_shift_reg <= '0;
			slot_len_reg <= CNT_W'(SLOT_BITS);
		end else if (rx_bound) begin
			rx_cnt_reg <= '0;
			rx_ws_reg <= ws_rx;
			rx_primed_reg <= 1'b1;
			if (rx_primed_reg) begin
				slot_len_reg <= rx_cnt_reg + 1'b1;
			end
			rx_shift_reg <= (right_just || data_index('0, res_bits(res), slot_len) >= 0)
				? (lsb_first ? {sd_sync_reg[1], 23'h000000} : {23'h000000, sd_sync_reg[1]})
				: '0;
		end else if (rx_rise) begin
			if (rx_cnt_reg != '1) begin
				rx_cnt_reg <= rx_cnt_reg + 1'b1;
			end
			if (right_just || data_index(rx_cnt_reg + 1'b1, res_bits(res), slot_len) >= 0) begin
				rx_shift_reg <= lsb_first ? {sd_sync_reg[1], rx_shift_reg[23:1]}
					: {rx_shift_reg[22:0], sd_sync_reg[1]};
			end
		end
	end

	// Received samples land in the register of their channel.
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_left_reg <= 16'h0000;
			rx_right_reg <= 16'h0000;
		end else if (deliver && deliver_left) begin
			rx_left_reg <= rx_conv;
		end else if (deliver) begin
			rx_right_reg <= rx_conv;
		end
	end

	// Ready flag: set by a right sample, cleared by reading it; the set wins.
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_ready_reg <= 1'b0;
		end else if (deliver && !deliver_left) begin
			rx_ready_reg <= 1'b1;
		end else if (reg_read && reg_addr == REG_RX_RIGHT) begin
			rx_ready_reg <= 1'b0;
		end
	end

	// Register writes.
	always_ff @(posedge clk) begin
		if (reset) begin
			config_reg <= CFG_RESET;
			ctrl_reg <= CTRL_RESET;
			tx_left_reg <= 16'h0000;
			tx_right_reg <= 16'h0000;
		end else if (reg_write) begin
			unique case (reg_addr)
				REG_CONFIG: config_reg <= reg_wdata & CFG_MASK;
				REG_CTRL: ctrl_reg <= reg_wdata[2:0];
				REG_TX_LEFT: tx_left_reg <= reg_wdata;
				REG_TX_RIGHT: tx_right_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Register reads answer one cycle later; unmapped offsets read zero.
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_reg <= 16'h0000;
		end else if (reg_read) begin
			unique case (reg_addr)
				REG_CONFIG: rdata_reg <= config_reg;
				REG_CTRL: rdata_reg <= {13'h0000, ctrl_reg};
				REG_TX_LEFT: rdata_reg <= tx_left_reg;
				REG_TX_RIGHT: rdata_reg <= tx_right_reg;
				REG_RX_LEFT: rdata_reg <= rx_left_reg;
				REG_RX_RIGHT: rdata_reg <= rx_right_reg;
				REG_STATUS: rdata_reg <= {14'h0000, rx_primed_reg, rx_ready_reg};
				default: rdata_reg <= 16'h0000;
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	assign reg_rdata = rdata_reg;
	assign sck_out = sck_out_reg;
	assign sck_oe = sck_oe_reg;
	assign ws_out = ws_out_reg;
	assign ws_oe = ws_oe_reg;
	assign sd_out = sd_out_reg;
	assign sd_oe = sd_oe_reg;
	assign pcm_owns_pins = pcm_reg;

	// Checks on pin ownership, framing and sample handling.
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	pins_release_a: assert property (
		!en |=> !sd_oe && !sck_oe && !ws_oe && pcm_owns_pins)
		else $error("pins still driven while port disabled");
	master_drive_a: assert property (
		en && master |=> sck_oe && ws_oe && !pcm_owns_pins)
		else $error("master does not drive clock and word select");
	ws_on_fall_a: assert property (
		$changed(ws_out_reg) && en && master |-> $fell(sck_out_reg))
		else $error("word select moved away from a falling clock edge");
	sck_half_a: assert property (
		en && master && $changed(sck_out_reg) |=> $stable(sck_out_reg))
		else $error("bit clock half period shorter than two cycles");
	msb_first_a: assert property (
		tx_bound && !right_just && !msb_delay && !lsb_first |=> sd_out_reg == $past(tx_conv[15]))
		else $error("MSB not in first period after WS change");
	delay_one_a: assert property (
		tx_bound && !right_just && msb_delay |=> !sd_out_reg)
		else $error("first period not empty with one period MSB delay");
	spare_zero_a: assert property (
		tx_fall && !tx_bound && !right_just && (tx_cnt_reg >= 6'd16) |=> !sd_out_reg)
		else $error("more than sixteen data bits sent in a slot");
	crop_res16_a: assert property (
		deliver && deliver_left && crop && !lsb_first && res != RES_20 && res != RES_24
		|=> rx_left_reg == $past(rx_shift_reg[15:0]))
		else $error("16-bit cropped sample wrong");
	crop_res24_a: assert property (
		deliver && deliver_left && crop && !lsb_first && res == RES_24
		|=> rx_left_reg == $past(rx_shift_reg[23:8]))
		else $error("24-bit cropped sample wrong");
	polarity_a: assert property (
		deliver && !deliver_left |=> $stable(rx_left_reg) && rx_ready_reg)
		else $error("right channel sample reached the left register");
	config_reset_a: assert property (
		$past(reset) |-> config_reg == 16'h0406)
		else $error("configuration not standard I2S after reset");

	master_frame_c: cover property (en && master && tx_bound ##[1:300] tx_bound);
	slave_rx_c: cover property (en && !master && deliver && !deliver_left);
	ready_read_c: cover property (rx_ready_reg ##1 reg_read && reg_addr == REG_RX_RIGHT);
endmodule
`default_nettype wire

// ---- dv/dasp_codec_model.sv ----
// Behavioural codec at the far side of the audio port: clocks, framing and sample words.
`default_nettype none
module dasp_codec_model (
	// Control from the bench.
	input  wire logic        gen,
	input  wire logic [5:0]  lead,
	input  wire logic [15:0] tx_l,
	input  wire logic [15:0] tx_r,
	input  wire logic        lsb,
	// Link pins as seen on the board.
	input  wire logic        sck,
	input  wire logic        ws,
	input  wire logic        sd_dut,
	output logic             sck_gen,
	output logic             ws_gen,
	output logic             sd_codec,
	// Words taken from the port and a count of slots seen.
	output logic [15:0]      rx_l,
	output logic [15:0]      rx_r,
	output logic [7:0]       slots
);
	timeunit 1ns;
	timeprecision 1ps;

	logic        ws_prev;
	logic [5:0]  per;
	logic [5:0]  idx;
	logic [3:0]  bit_no;
	logic [15:0] shift;
	int          falls;

	// Everything starts quiet with the clocks standing low.
	initial begin
		sck_gen = 1'b0;
		ws_gen = 1'b0;
		sd_codec = 1'b0;
		rx_l = 16'h0000;
		rx_r = 16'h0000;
		slots = 8'h00;
		ws_prev = 1'b0;
		per = 6'h00;
		idx = 6'h00;
		shift = 16'h0000;
		falls = 0;
	end

	// A 400 ns bit clock and 32 periods a slot; it stands still when not asked for.
	always begin
		if (gen) begin
			#200 sck_gen = 1'b1;
			#200 sck_gen = 1'b0;
			falls = falls + 1;
			if (falls % 32 == 0)
				ws_gen = ~ws_gen;
		end else begin
			@(gen);
			// Pin edges stay clear of system clock edges, so that clock and word select
			// always reach the port's synchronisers in the same cycle.
			#10;
		end
	end

	// Each word select change starts a slot; the word sits at periods lead to lead+15.
	always @(negedge sck) begin
		#1;
		if (ws !== ws_prev) begin
			if (ws_prev)
				rx_r = shift;
			else
				rx_l = shift;
			slots = slots + 8'h01;
			ws_prev = ws;
			per = 6'h00;
		end else if (per != 6'h3f) begin
			per = per + 6'h01;
		end
		idx = per - lead;
		bit_no = lsb ? idx[3:0] : 4'hf - idx[3:0];
		if (per >= lead && idx < 6'd16)
			sd_codec = ws ? tx_r[bit_no] : tx_l[bit_no];
		else
			sd_codec = 1'b0;
	end

	// Data from the port is taken on the rising bit clock, MSB first unless lsb is set.
	always @(posedge sck) begin
		if (per >= lead && idx < 6'd16)
			shift = lsb ? {sd_dut, shift[15:1]} : {shift[14:0], sd_dut};
	end
endmodule
`default_nettype wire

// ---- dv/dasp_port_tb.sv ----
// Self-checking bench of the audio serial port against the codec model.
`default_nettype none
module dasp_port_tb;
	import dasp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk;
	logic              reset;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_write;
	logic              reg_read;
	logic [DATA_W-1:0] reg_rdata;
	logic              sck_out;
	logic              sck_oe;
	logic              ws_out;
	logic              ws_oe;
	logic              sd_out;
	logic              sd_oe;
	logic              pcm_owns_pins;
	logic              sck_w;
	logic              ws_w;
	logic              sd_codec;
	logic              sck_gen;
	logic              ws_gen;
	logic              gen;
	logic [5:0]        lead;
	logic [15:0]       m_tx_l;
	logic [15:0]       m_tx_r;
	logic              m_lsb;
	logic [15:0]       m_rx_l;
	logic [15:0]       m_rx_r;
	logic [15:0]       got;
	logic [15:0]       t_l;
	logic [15:0]       t_r;
	logic [7:0]        slots;
	logic [7:0]        s0;
	int                bad_count;
	int                samples_checked;
	int                cycles;
	int                i;
	int                k;
	logic [15:0]       cfg_tab [8] = '{16'h0406, 16'h0404, 16'h0405, 16'h0402, 16'h004e, 16'h0706,
		16'h0606, 16'h0106};
	logic [5:0]        lead_tab [8] = '{6'd1, 6'd0, 6'd16, 6'd1, 6'd1, 6'd1, 6'd1, 6'd1};

	// Board wiring: whoever enables its driver owns the clock lines.
	assign sck_w = sck_oe ? sck_out : sck_gen;
	assign ws_w = ws_oe ? ws_out : ws_gen;

	// 50 ns clock.
	initial clk = 1'b0;
	always #25 clk = ~clk;

	dasp_port #(.SCK_HALF(4), .SLOT_BITS(32)) dut (
		.clk           (clk),
		.reset         (reset),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_write     (reg_write),
		.reg_read      (reg_read),
		.reg_rdata     (reg_rdata),
		.sck_in        (sck_w),
		.sck_out       (sck_out),
		.sck_oe        (sck_oe),
		.ws_in         (ws_w),
		.ws_out        (ws_out),
		.ws_oe         (ws_oe),
		.sd_in         (sd_codec),
		.sd_out        (sd_out),
		.sd_oe         (sd_oe),
		.pcm_owns_pins (pcm_owns_pins)
	);

	dasp_codec_model codec (
		.gen      (gen),
		.lead     (lead),
		.tx_l     (m_tx_l),
		.tx_r     (m_tx_r),
		.lsb      (m_lsb),
		.sck      (sck_w),
		.ws       (ws_w),
		.sd_dut   (sd_out),
		.sck_gen  (sck_gen),
		.ws_gen   (ws_gen),
		.sd_codec (sd_codec),
		.rx_l     (m_rx_l),
		.rx_r     (m_rx_r),
		.slots    (slots)
	);

	// Counts one comparison and reports a difference.
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, seen);
			bad_count++;
		end
	endtask

	// One-cycle register write.
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	// One-cycle register read; data is taken in the following cycle only.
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask

	// Sample the port sends: attenuated only with bit 3 set and crop clear.
	function automatic logic [15:0] exp_tx(input logic [15:0] c, input logic [15:0] x);
		logic signed [23:0] t;
		t = $signed({x, 8'h00}) >>> c[7:4];
		t = t + 24'sh000080;
		return (c[3] && !c[10]) ? t[23:8] : x;
	endfunction

	// One framing run as master or slave, with random words both ways.
	task automatic run(input logic [15:0] c, input logic [5:0] ld, input logic mst, input logic lsb);
		wr(REG_CTRL, 16'h0000);
		wr(REG_CONFIG, c);
		t_l = 16'($urandom);
		t_r = 16'($urandom);
		wr(REG_TX_LEFT, t_l);
		wr(REG_TX_RIGHT, t_r);
		m_tx_l <= 16'($urandom);
		m_tx_r <= 16'($urandom);
		lead <= ld;
		m_lsb <= lsb;
		gen <= ~mst;
		wr(REG_CTRL, {13'h0000, lsb, mst, 1'b1});
		repeat (2) @(posedge clk);
		chk("pins_on", {12'h000, mst, mst, 2'b10}, {12'h000, sck_oe, ws_oe, sd_oe, pcm_owns_pins});
		s0 = slots;
		k = 0;
		while (8'(slots - s0) < 8'd6 && k < 6000) begin
			@(posedge clk);
			k++;
		end
		chk("slots", 16'h0006, {8'h00, 8'(slots - s0)});
		rd(REG_STATUS, got);
		chk("status", 16'h0003, got);
		rd(REG_RX_LEFT, got);
		chk("rx_left", c[2] ? m_tx_l : m_tx_r, got);
		rd(REG_RX_RIGHT, got);
		chk("rx_right", c[2] ? m_tx_r : m_tx_l, got);
		chk("codec_left", exp_tx(c, c[2] ? t_l : t_r), m_rx_l);
		chk("codec_right", exp_tx(c, c[2] ? t_r : t_l), m_rx_r);
		gen <= 1'b0;
		wr(REG_CTRL, 16'h0000);
		repeat (2) @(posedge clk);
		chk("pins_off", 16'h0001, {12'h000, sck_oe, ws_oe, sd_oe, pcm_owns_pins});
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Cuts a hang short well beyond the length of the planned runs.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			give_verdict();
		end
	end

	// Main sequence: reset, register map, then every framing in both clock roles.
	initial begin
		reset = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		gen = 1'b0;
		lead = 6'h00;
		m_tx_l = 16'h0000;
		m_tx_r = 16'h0000;
		m_lsb = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		cycles = 0;
		k = $urandom(3);
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		chk("pins_reset", 16'h0001, {12'h000, sck_oe, ws_oe, sd_oe, pcm_owns_pins});
		rd(REG_CONFIG, got);
		chk("config_reset", 16'h0406, got);
		rd(REG_CTRL, got);
		chk("ctrl_reset", 16'h0000, got);
		rd(3'h7, got);
		chk("unmapped", 16'h0000, got);
		wr(REG_RX_LEFT, 16'hbeef);
		rd(REG_RX_LEFT, got);
		chk("rx_left_ro", 16'h0000, got);
		wr(REG_CONFIG, 16'hffff);
		rd(REG_CONFIG, got);
		chk("config_mask", 16'h07ff, got);
		for (i = 0; i < 8; i++) begin
			run(cfg_tab[i], lead_tab[i], 1'b1, 1'b0);
			run(cfg_tab[i], lead_tab[i], 1'b0, 1'b0);
		end
		run(16'h0406, 6'd1, 1'b1, 1'b1);
		run(16'h0406, 6'd1, 1'b0, 1'b1);
		give_verdict();
	end
endmodule
`default_nettype wire
